// >>> src/fap_pkg.sv
// fap_pkg: shared constants and types of the floating-point datapath
// assumes: included first; every user names items as fap_pkg::name
`default_nettype none

package fap_pkg;
	// register map, byte addresses of 32-bit words
	localparam int AXI_AW = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control word fields
	localparam int CTRL_OP = 0;
	localparam int CTRL_FMT = 3;
	localparam int CTRL_SSRC = 4;
	localparam int CTRL_RSRC = 5;
	localparam int CTRL_IPASS = 6;
	localparam int CTRL_OPASS = 7;
	localparam int CTRL_IO = 8;
	localparam int CTRL_W = 10;
	localparam logic [9:0] CTRL_RST = 10'h008;
	// flag positions
	localparam int FLG_INV = 0;
	localparam int FLG_OVF = 1;
	localparam int FLG_UNF = 2;
	localparam int FLG_NAN = 3;
	localparam int FLG_INEX = 4;
	localparam int FLG_ZERO = 5;
	localparam int FLG_W = 6;
	typedef enum logic [2:0] {
		OP_ADD = 3'h0, OP_SUB = 3'h1, OP_MUL = 3'h2, OP_TWO_MINUS = 3'h3,
		OP_ITOF = 3'h4, OP_FTOI = 3'h5, OP_TO_ALT = 3'h6, OP_FROM_ALT = 3'h7
	} fap_op_t;
	typedef enum logic [1:0] {
		IO_TWO = 2'h0, IO_ONE = 2'h1, IO_HALF = 2'h2, IO_BAD = 2'h3
	} fap_iomode_t;
	// exponent arithmetic, ieee-biased except ALT_TOP (alternate field) and INT_LIM (unbiased)
	localparam logic signed [9:0] ALT_OFS = 10'sh002;
	localparam logic signed [9:0] ZERO_EXP = -10'sh100;
	localparam logic signed [9:0] ITOF_EXP = 10'sh09e;
	localparam logic signed [9:0] MUL_ADJ = 10'sh07e;
	localparam logic signed [9:0] IEEE_TOP = 10'sh0fe;
	localparam logic signed [9:0] ALT_TOP = 10'sh0ff;
	localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
	localparam logic signed [9:0] INT_LIM = 10'sh01f;
	localparam logic [31:0] QNAN = 32'h7fa0_0000;
	localparam logic [31:0] RSV_WORD = 32'h8000_0000;
	localparam logic [31:0] INT_MAX = 32'h7fff_ffff;
	localparam logic [31:0] INT_MIN = 32'h8000_0000;
	typedef struct packed {
		logic sgn;
		logic zero;
		logic inf;
		logic nan;
		logic signed [9:0] exp;
		logic [23:0] man;
	} fap_unp_t;
	localparam fap_unp_t TWO_UNP = '{1'b0, 1'b0, 1'b0, 1'b0, 10'sh080, 24'h80_0000};
endpackage : fap_pkg

`default_nettype wire

// >>> src/fap_opreg_if.sv
// fap_opreg_if: ties one operand register to the datapath core
// assumes: fap_pkg compiled before
`default_nettype none

interface fap_opreg_if;
	logic [31:0] bus;
	logic [31:0] alt;
	logic alt_sel;
	logic load_n;
	logic pass;
	fap_pkg::fap_iomode_t iomode;
	logic [31:0] q;
	modport owner (output bus, output alt, output alt_sel, output load_n, output pass,
		output iomode, input q);
	modport store (input bus, input alt, input alt_sel, input load_n, input pass,
		input iomode, output q);
endinterface : fap_opreg_if

`default_nettype wire

// >>> src/fap_opreg.sv
// fap_opreg: one operand register with falling-edge holding stage
// assumes: host keeps passthrough low in shared and half-width modes
`default_nettype none

module fap_opreg #(
	parameter bit IS_S = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	fap_opreg_if.store p
);
	logic [31:0] hold_q;
	logic [31:0] word;
	logic [31:0] reg_q;

	// bus sampled on the falling edge
	always_ff @(negedge aclk)
	begin
		if (!aresetn)
			hold_q <= 32'h0;
		else
			hold_q <= p.bus;
	end

	// word assembled per bus configuration
	always_comb
	begin
		case (p.iomode)
			fap_pkg::IO_HALF: word = {p.bus[31:16], hold_q[15:0]};
			fap_pkg::IO_ONE: word = IS_S ? hold_q : p.bus;
			default: word = p.bus;
		endcase
	end

	// edge load; feedback only into the register, never through passthrough
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reg_q <= 32'h0;
		else if (!p.load_n)
			reg_q <= p.alt_sel ? p.alt : word;
	end

	assign p.q = p.pass ? word : reg_q;

	hold_load_a:
	assert property (@(posedge aclk) disable iff (!aresetn)
		p.iomode == fap_pkg::IO_ONE && IS_S && !p.load_n && !p.alt_sel
		|=> reg_q == $past(hold_q))
	else $error("shared-bus s load missed holding value");

	half_word_a:
	assert property (@(posedge aclk) disable iff (!aresetn)
		p.iomode == fap_pkg::IO_HALF && !p.load_n && !p.alt_sel
		|=> reg_q == {$past(p.bus[31:16]), $past(hold_q[15:0])})
	else $error("half-width word misassembled");
endmodule : fap_opreg

`default_nettype wire

// >>> src/fap_datapath.sv
// fap_datapath: floating-point alu with registered three-bus datapath
// assumes: host logic on aclk drives buses and strobes; axi4-lite master
// Operation
// - op code picks one of eight operations
// - format bit picks ieee or alternate arithmetic
// - two minus s ignores r
// - r integer to float, s ignored
// - r float to integer, s ignored
// - cross-format conversion independent of format bit
// - six flags captured each rising edge
// - output passthrough opens result and flags
// - result bus driven only while enable low
// - active-low load per register, else hold
// - input passthrough opens r and s
// - r source: bus or alu result
// - alu s port: register s or result
// - bus configuration codes, 11 illegal
// - configuration never changes the arithmetic
// - two-bus mode loads on rising edge
// - shared bus: s via falling-edge hold
// - half width: low falling, high rising
// - half width: low half clock high
`default_nettype none

module fap_datapath (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fap_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [fap_pkg::AXI_AW-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic [31:0] r_bus_in,
	input wire logic [31:0] s_bus_in,
	input wire logic r_reg_load_n,
	input wire logic s_reg_load_n,
	input wire logic result_reg_load_n,
	input wire logic result_out_en_n,
	output logic [31:0] result_out,
	output logic [1:0] result_oe,
	output logic [fap_pkg::FLG_W-1:0] flags_out
);
	logic [fap_pkg::CTRL_W-1:0] ctrl_q;
	logic aw_have_q;
	logic [fap_pkg::AXI_AW-1:0] aw_addr_q;
	logic w_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;
	logic wr_ctrl;
	logic [15:0] wmask;
	logic [fap_pkg::CTRL_W-1:0] ctrl_new;
	logic io_illegal;
	fap_pkg::fap_op_t op;
	fap_pkg::fap_iomode_t iomode;
	logic fmt_ieee;
	logic opass;
	logic [31:0] f_q;
	logic [fap_pkg::FLG_W-1:0] flag_q;
	logic [31:0] f_view;
	logic [31:0] alu_r;
	logic [31:0] alu_s;
	logic [31:0] alu_f;
	logic [fap_pkg::FLG_W-1:0] alu_flags;
	logic in_alt;
	logic out_alt;
	fap_pkg::fap_unp_t ua;
	fap_pkg::fap_unp_t ub;
	logic bsgn;
	logic swap;
	logic signed [9:0] hx;
	logic [9:0] dx;
	logic [26:0] hm;
	logic [26:0] lm;
	logic [26:0] lm_sh;
	logic [27:0] sum;
	logic [47:0] nv;
	logic [47:0] nsh;
	logic signed [9:0] ne;
	logic signed [9:0] nexp;
	logic signed [9:0] pe;
	logic [5:0] lz;
	logic rsgn;
	logic sticky;
	logic is_int;
	logic [54:0] ifull;
	logic signed [9:0] tx;
	logic [31:0] imag;
	logic uses_s;
	logic clash;
	logic spec_inf;
	logic isgn;

	fap_opreg_if r_if ();
	fap_opreg_if s_if ();

	// unpack to ieee-biased exponent; zero gets a tiny exponent so it aligns away
	function automatic fap_pkg::fap_unp_t unpack(input logic [31:0] w, input logic alt);
		fap_pkg::fap_unp_t u;
		u.sgn = w[31];
		u.zero = (w[30:23] == 8'h00) && !(alt && w[31]);
		u.inf = !alt && (w[30:23] == 8'hff) && (w[22:0] == 23'h0);
		u.nan = alt ? (w[30:23] == 8'h00 && w[31]) : (w[30:23] == 8'hff && w[22:0] != 23'h0);
		u.exp = u.zero ? fap_pkg::ZERO_EXP :
			$signed({2'b00, w[30:23]}) - (alt ? fap_pkg::ALT_OFS : 10'sh000);
		u.man = u.zero ? 24'h0 : {1'b1, w[22:0]};
		return u;
	endfunction : unpack

	// control word fields
	assign op = fap_pkg::fap_op_t'(ctrl_q[fap_pkg::CTRL_OP +: 3]);
	assign fmt_ieee = ctrl_q[fap_pkg::CTRL_FMT];
	assign opass = ctrl_q[fap_pkg::CTRL_OPASS];
	assign iomode = fap_pkg::fap_iomode_t'(ctrl_q[fap_pkg::CTRL_IO +: 2]);

	// axi write side: address and data taken in either order
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
	assign wr_ctrl = aw_addr_q[7:2] == fap_pkg::ADDR_CTRL[7:2];
	assign wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign ctrl_new = (ctrl_q & ~wmask[9:0]) | (w_data_q[9:0] & wmask[9:0]);
	assign io_illegal = ctrl_new[fap_pkg::CTRL_IO +: 2] == fap_pkg::IO_BAD;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_have_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_have_q <= 1'b0;
	end

	// write response; unmapped, read-only or illegal mode answers slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= fap_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_ctrl && !io_illegal) ? fap_pkg::RESP_OKAY : fap_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// control register; code 11 for bus mode is refused whole
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl_q <= fap_pkg::CTRL_RST;
		else if (wr_fire && wr_ctrl && !io_illegal)
			ctrl_q <= ctrl_new;
	end

	// axi read side
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= fap_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= fap_pkg::RESP_OKAY;
			case (s_axi_araddr[7:2])
				fap_pkg::ADDR_CTRL[7:2]: rdata_q <= {22'h0, ctrl_q};
				fap_pkg::ADDR_FLAGS[7:2]: rdata_q <= {26'h0, flags_out};
				fap_pkg::ADDR_RESULT[7:2]: rdata_q <= f_view;
				default:
				begin
					rdata_q <= 32'h0;
					rresp_q <= fap_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// operand registers r and s
	assign r_if.bus = r_bus_in;
	assign r_if.alt = alu_f;
	assign r_if.alt_sel = ctrl_q[fap_pkg::CTRL_RSRC];
	assign r_if.load_n = r_reg_load_n;
	assign r_if.pass = ctrl_q[fap_pkg::CTRL_IPASS];
	assign r_if.iomode = iomode;
	assign s_if.bus = s_bus_in;
	assign s_if.alt = 32'h0;
	assign s_if.alt_sel = 1'b0;
	assign s_if.load_n = s_reg_load_n;
	assign s_if.pass = ctrl_q[fap_pkg::CTRL_IPASS];
	assign s_if.iomode = iomode;

	fap_opreg #(.IS_S(1'b0)) u_r_reg (.aclk(aclk), .aresetn(aresetn), .p(r_if.store));
	fap_opreg #(.IS_S(1'b1)) u_s_reg (.aclk(aclk), .aresetn(aresetn), .p(s_if.store));

	// alu ports; s port feeds back the stored result
	assign alu_r = r_if.q;
	assign alu_s = ctrl_q[fap_pkg::CTRL_SSRC] ? f_q : s_if.q;
	assign in_alt = (op == fap_pkg::OP_FROM_ALT) || (op != fap_pkg::OP_TO_ALT && !fmt_ieee);
	assign out_alt = (op == fap_pkg::OP_TO_ALT) || (op != fap_pkg::OP_FROM_ALT && !fmt_ieee);
	assign ua = (op == fap_pkg::OP_TWO_MINUS) ? fap_pkg::TWO_UNP : unpack(alu_r, in_alt);
	assign ub = unpack(alu_s, in_alt);
	assign bsgn = ub.sgn ^ (op == fap_pkg::OP_SUB || op == fap_pkg::OP_TWO_MINUS);
	assign uses_s = !op[2];

	// add path: larger magnitude first, smaller aligned with sticky bit
	assign swap = (ub.exp > ua.exp) || (ub.exp == ua.exp && ub.man > ua.man);
	assign hx = swap ? ub.exp : ua.exp;
	assign dx = swap ? 10'(ub.exp - ua.exp) : 10'(ua.exp - ub.exp);
	assign hm = swap ? {ub.man, 3'h0} : {ua.man, 3'h0};
	assign lm = swap ? {ua.man, 3'h0} : {ub.man, 3'h0};
	assign lm_sh = lm >> dx;
	assign sum = (ua.sgn != bsgn) ? ({1'b0, hm} - {1'b0, lm_sh}) : ({1'b0, hm} + {1'b0, lm_sh});

	// float to integer, truncating
	assign tx = ua.exp - fap_pkg::EXP_BIAS;
	assign ifull = {31'h0, ua.man} << tx[4:0];
	assign imag = ifull[54:23];

	// operation select; all paths except float to integer meet in one normalizer and packer
	always_comb
	begin
		nv = 48'h0;
		ne = 10'sh000;
		rsgn = 1'b0;
		sticky = 1'b0;
		is_int = 1'b0;
		case (op)
			fap_pkg::OP_MUL:
			begin
				nv = 48'(ua.man) * 48'(ub.man);
				ne = ua.exp + ub.exp - fap_pkg::MUL_ADJ;
				rsgn = ua.sgn ^ ub.sgn;
			end
			fap_pkg::OP_ITOF:
			begin
				nv = {(alu_r[31] ? 32'(-alu_r) : alu_r), 16'h0};
				ne = fap_pkg::ITOF_EXP;
				rsgn = alu_r[31];
			end
			fap_pkg::OP_FTOI:
				is_int = 1'b1;
			fap_pkg::OP_TO_ALT, fap_pkg::OP_FROM_ALT:
			begin
				nv = {ua.man, 24'h0};
				ne = ua.exp;
				rsgn = ua.sgn;
			end
			default:
			begin
				nv = {sum, 20'h0};
				ne = hx + 10'sh001;
				rsgn = swap ? bsgn : ua.sgn;
				sticky = (lm_sh << dx) != lm;
			end
		endcase
	end

	// leading one search
	always_comb
	begin
		lz = 6'h0;
		for (int i = 0; i < 48; i++)
		begin
			if (nv[i])
				lz = 6'(47 - i);
		end
	end

	assign nsh = nv << lz;
	assign nexp = ne - $signed({4'h0, lz});
	assign pe = nexp + (out_alt ? fap_pkg::ALT_OFS : 10'sh000);
	assign clash = (uses_s && op != fap_pkg::OP_MUL && ua.inf && ub.inf && ua.sgn != bsgn)
		|| (op == fap_pkg::OP_MUL && ((ua.inf && ub.zero) || (ub.inf && ua.zero)));
	assign spec_inf = (ua.inf || (uses_s && ub.inf)) && !op[2];
	assign isgn = (op == fap_pkg::OP_MUL) ? (ua.sgn ^ ub.sgn) : (ua.inf ? ua.sgn : bsgn);

	// pack result and raise flags; specials override the numeric path
	always_comb
	begin
		alu_f = 32'h0;
		alu_flags = '0;
		if (is_int)
		begin
			if (ua.nan || ua.inf || tx > fap_pkg::INT_LIM
				|| (tx == fap_pkg::INT_LIM && !(ua.sgn && ua.man == 24'h80_0000)))
			begin
				alu_flags[fap_pkg::FLG_INV] = 1'b1;
				alu_f = ua.sgn ? fap_pkg::INT_MIN : fap_pkg::INT_MAX;
			end
			else if (tx < 10'sh000)
				alu_flags[fap_pkg::FLG_INEX] = !ua.zero;
			else
			begin
				alu_f = ua.sgn ? 32'(-imag) : imag;
				alu_flags[fap_pkg::FLG_INEX] = |ifull[22:0];
			end
		end
		else if (ua.nan || (uses_s && ub.nan) || clash || (out_alt && spec_inf))
		begin
			alu_f = out_alt ? fap_pkg::RSV_WORD : fap_pkg::QNAN;
			alu_flags[fap_pkg::FLG_NAN] = 1'b1;
			alu_flags[fap_pkg::FLG_INV] = 1'b1;
		end
		else if (spec_inf)
			alu_f = {isgn, 8'hff, 23'h0};
		else if (nv != 48'h0)
		begin
			alu_flags[fap_pkg::FLG_INEX] = (|nsh[23:0]) || sticky;
			if (pe > (out_alt ? fap_pkg::ALT_TOP : fap_pkg::IEEE_TOP))
			begin
				alu_flags[fap_pkg::FLG_OVF] = 1'b1;
				alu_flags[fap_pkg::FLG_NAN] = out_alt;
				alu_f = out_alt ? fap_pkg::RSV_WORD : {rsgn, 8'hff, 23'h0};
			end
			else if (pe < 10'sh001)
			begin
				alu_flags[fap_pkg::FLG_UNF] = 1'b1;
				alu_flags[fap_pkg::FLG_INEX] = 1'b1;
			end
			else
				alu_f = {rsgn, pe[7:0], nsh[46:24]};
		end
		alu_flags[fap_pkg::FLG_ZERO] = !alu_flags[fap_pkg::FLG_NAN]
			&& (is_int ? alu_f == 32'h0 : alu_f[30:0] == 31'h0 && !spec_inf);
	end

	// result register with its own load strobe
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			f_q <= 32'h0;
		else if (!result_reg_load_n)
			f_q <= alu_f;
	end

	// flag register loads on every edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_q <= '0;
		else
			flag_q <= alu_flags;
	end

	// output side: passthrough, enable, half-width lane split
	assign f_view = opass ? alu_f : f_q;
	assign flags_out = opass ? alu_flags : flag_q;
	assign result_out = f_view;
	assign result_oe[0] = !result_out_en_n && (iomode != fap_pkg::IO_HALF || aclk);
	assign result_oe[1] = !result_out_en_n && (iomode != fap_pkg::IO_HALF || !aclk);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence res_load_s;
		!result_reg_load_n && !opass;
	endsequence

	res_load_a:
	assert property (res_load_s |=> f_q == $past(alu_f))
	else $error("result register missed its load");

	res_hold_a:
	assert property (result_reg_load_n |=> f_q == $past(f_q))
	else $error("result register changed while disabled");

	flag_cap_a:
	assert property (!opass ##1 !opass |-> flags_out == $past(alu_flags))
	else $error("flag register not captured");

	out_pass_a:
	assert property (opass |-> result_out == alu_f && flags_out == alu_flags)
	else $error("output passthrough not transparent");

	oe_off_a:
	assert property (result_out_en_n |-> result_oe == 2'h0)
	else $error("result bus driven while disabled");

	two_minus_a:
	assert property (op == fap_pkg::OP_TWO_MINUS && fmt_ieee && alu_s == 32'h4000_0000
		|-> alu_flags[fap_pkg::FLG_ZERO] && alu_f == 32'h0)
	else $error("two minus two not zero");

	itof_one_a:
	assert property (op == fap_pkg::OP_ITOF && fmt_ieee && alu_r == 32'h1
		|-> alu_f == 32'h3f80_0000)
	else $error("integer one not converted");

	ftoi_one_a:
	assert property (op == fap_pkg::OP_FTOI && fmt_ieee && alu_r == 32'h3f80_0000
		|-> alu_f == 32'h1)
	else $error("float one not converted");

	io_legal_a:
	assert property (iomode != fap_pkg::IO_BAD)
	else $error("illegal bus mode stored");
endmodule : fap_datapath

`default_nettype wire

// >>> test/fap_host.sv
// fap_host: host logic feeding the operand buses of the datapath
// assumes: mode tracks the bus configuration written to the control word
`default_nettype none

module fap_host (
	input wire logic aclk,
	input wire logic [1:0] mode,
	input wire logic [31:0] r_word,
	input wire logic [31:0] s_word,
	output logic [31:0] r_bus,
	output logic [31:0] s_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	// buses start defined before the first edge
	initial
	begin
		r_bus = 32'h0;
		s_bus = 32'h0;
	end

	// high phase: s word on shared bus, low halves in half width
	always @(posedge aclk)
	begin
		r_bus <= (mode == 2'h1) ? s_word : (mode == 2'h2) ?
			{~r_word[31:16], r_word[15:0]} : r_word;
		s_bus <= (mode == 2'h2) ? {~s_word[31:16], s_word[15:0]} : s_word;
	end

	// low phase: r word on shared bus, high halves, stale halves inverted
	always @(negedge aclk)
	begin
		r_bus <= (mode == 2'h2) ? {r_word[31:16], ~r_word[15:0]} : r_word;
		s_bus <= (mode == 2'h1) ? r_word : (mode == 2'h2) ?
			{s_word[31:16], ~s_word[15:0]} : s_word;
	end
endmodule : fap_host

`default_nettype wire

// >>> test/fap_datapath_tb.sv
// fap_datapath_tb: self-checking bench for the floating-point datapath
// assumes: fap_pkg, fap_host and the design compiled before
`default_nettype none

module fap_datapath_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, r_bus_in, s_bus_in, result_out, r_word, s_word;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, result_oe, hmode;
	logic r_reg_load_n, s_reg_load_n, result_reg_load_n, result_out_en_n;
	logic [fap_pkg::FLG_W-1:0] flags_out;
	int err_total, check_count, cyc, i;
	// {fmt, op}, r, s, expected result
	localparam logic [99:0] TV [17] = '{
		{4'h8, 32'h3f800000, 32'h40000000, 32'h40400000},
		{4'h9, 32'h3f800000, 32'h40000000, 32'hbf800000},
		{4'ha, 32'h40000000, 32'h40400000, 32'h40c00000},
		{4'hb, 32'h12345678, 32'h3f000000, 32'h3fc00000},
		{4'hb, 32'hc0000000, 32'h3f000000, 32'h3fc00000},
		{4'hc, 32'h00000005, 32'hdeadbeef, 32'h40a00000},
		{4'hd, 32'hc1360000, 32'h00000000, 32'hfffffff5},
		{4'he, 32'h3f800000, 32'h40000000, 32'h40800000},
		{4'hf, 32'h40800000, 32'h40000000, 32'h3f800000},
		{4'h2, 32'h40800000, 32'h41000000, 32'h41000000},
		{4'h4, 32'h00000005, 32'h00000000, 32'h41a00000},
		{4'h5, 32'h41a00000, 32'h00000000, 32'h00000005},
		{4'h6, 32'h3f800000, 32'h12345678, 32'h40800000},
		{4'hb, 32'h00000000, 32'h40000000, 32'h00000000},
		{4'hc, 32'h00000001, 32'h00000000, 32'h3f800000},
		{4'hd, 32'h3f800000, 32'h00000000, 32'h00000001},
		{4'h9, 32'h3f800000, 32'h3f800000, 32'h00000000}};

	fap_datapath dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .r_bus_in, .s_bus_in,
		.r_reg_load_n, .s_reg_load_n, .result_reg_load_n, .result_out_en_n, .result_out,
		.result_oe, .flags_out);
	fap_host host (.aclk, .mode(hmode), .r_word, .s_word, .r_bus(r_bus_in), .s_bus(s_bus_in));

	// 50 mhz clock
	always #10 aclk = ~aclk;

	// hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : wt

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic af, wf, bf;
		@(posedge aclk); // control words change with clock high
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			af = s_axi_awvalid && s_axi_awready;
			wf = s_axi_wvalid && s_axi_wready;
			bf = s_axi_bvalid;
			if (bf)
				chk({30'h0, s_axi_bresp}, {30'h0, er});
			@(posedge aclk);
			if (af)
				s_axi_awvalid <= 1'b0;
			if (wf)
				s_axi_wvalid <= 1'b0;
		end
		while (!bf);
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic af, rf;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			af = s_axi_arvalid && s_axi_arready;
			rf = s_axi_rvalid;
			if (rf)
			begin
				chk(s_axi_rdata, e);
				chk({30'h0, s_axi_rresp}, {30'h0, er});
			end
			@(posedge aclk);
			if (af)
				s_axi_arvalid <= 1'b0;
		end
		while (!rf);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic op_chk(input logic [31:0] c, input logic [31:0] r, input logic [31:0] s,
		input logic [31:0] e);
		axi_wr(fap_pkg::ADDR_CTRL, c, fap_pkg::RESP_OKAY);
		r_word <= r;
		s_word <= s;
		wt(4);
		chk(result_out, e);
	endtask : op_chk

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// main sequence
	initial
	begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{r_reg_load_n, s_reg_load_n, result_reg_load_n, result_out_en_n} = 4'hd;
		{hmode, r_word, s_word, cyc, err_total, check_count} = '0;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(fap_pkg::ADDR_CTRL, 32'h8, fap_pkg::RESP_OKAY);
		axi_rd(fap_pkg::ADDR_FLAGS, 32'h20, fap_pkg::RESP_OKAY);
		axi_rd(fap_pkg::ADDR_RESULT, 32'h0, fap_pkg::RESP_OKAY);
		$display("test reset done");
		@(posedge aclk);
		{r_reg_load_n, s_reg_load_n, result_reg_load_n, result_out_en_n} <= 4'h0;
		for (i = 0; i < 17; i++)
			op_chk({28'h0, TV[i][99:96]}, TV[i][95:64], TV[i][63:32], TV[i][31:0]);
		chk({26'h0, flags_out}, 32'h20);
		$display("test operations done");
		hmode <= 2'h1;
		op_chk(32'h109, 32'h40000000, 32'h3f800000, 32'h3f800000);
		@(posedge aclk);
		hmode <= 2'h2;
		op_chk(32'h20c, 32'h00012345, 32'h0, 32'h4791a280);
		#5 chk({30'h0, result_oe}, 32'h2);
		@(posedge aclk);
		#5 chk({30'h0, result_oe}, 32'h1);
		hmode <= 2'h0;
		op_chk(32'h8, 32'h3f800000, 32'h40000000, 32'h40400000);
		$display("test bus modes done");
		@(posedge aclk);
		r_reg_load_n <= 1'b1;
		r_word <= 32'h40000000;
		wt(4);
		chk(result_out, 32'h40400000);
		axi_wr(fap_pkg::ADDR_CTRL, 32'h28, fap_pkg::RESP_OKAY);
		r_reg_load_n <= 1'b0;
		@(posedge aclk);
		r_reg_load_n <= 1'b1;
		wt(3);
		chk(result_out, 32'h40a00000);
		@(posedge aclk);
		result_reg_load_n <= 1'b1;
		axi_wr(fap_pkg::ADDR_CTRL, 32'h18, fap_pkg::RESP_OKAY);
		result_reg_load_n <= 1'b0;
		@(posedge aclk);
		result_reg_load_n <= 1'b1;
		wt(2);
		chk(result_out, 32'h41000000);
		axi_wr(fap_pkg::ADDR_CTRL, 32'h88, fap_pkg::RESP_OKAY);
		wt(2);
		chk(result_out, 32'h40a00000);
		axi_rd(fap_pkg::ADDR_RESULT, 32'h40a00000, fap_pkg::RESP_OKAY);
		s_reg_load_n <= 1'b1;
		{r_word, s_word} <= {2{32'h3f800000}};
		axi_wr(fap_pkg::ADDR_CTRL, 32'hc8, fap_pkg::RESP_OKAY);
		wt(1);
		chk(result_out, 32'h40000000);
		@(posedge aclk);
		result_out_en_n <= 1'b1;
		wt(1);
		chk({30'h0, result_oe}, 32'h0);
		@(posedge aclk);
		result_out_en_n <= 1'b0;
		wt(1);
		chk({30'h0, result_oe}, 32'h3);
		$display("test registers done");
		axi_wr(fap_pkg::ADDR_CTRL, 32'h308, fap_pkg::RESP_SLVERR);
		axi_rd(fap_pkg::ADDR_CTRL, 32'hc8, fap_pkg::RESP_OKAY);
		axi_wr(fap_pkg::ADDR_FLAGS, 32'h0, fap_pkg::RESP_SLVERR);
		axi_rd(8'h0c, 32'h0, fap_pkg::RESP_SLVERR);
		$display("test refusals done");
		tally_and_finish();
	end
endmodule : fap_datapath_tb

`default_nettype wire
